// ==== rtl/dcc_channel.sv ====
// Contract
// - request selector picks triggering request line
// - frame mode moves one frame per request
// - block mode moves one block per request
// - otherwise one element per request
// - priority bit gives highest or lowest level
// - enable starts; clearing stops and resets channel
// - hardware enable clear beats processor write
// - autoinit reloads and restarts, else stops
// - enable clear stops now, autoinit clear later
// - autoinit with repeat restarts immediately
// - end_prog permits reload; else wait for it
// - legacy model bit selects programming model
// - addressing modes constant, increment, single, double
// - enabled event raises interrupt and status bit
// - timeout at either port interrupts when enabled
// - request during service signals event drop
// - half frame interrupt when enabled
// - frame done interrupt when enabled
// - last frame start interrupt when enabled
// - block done interrupt when enabled
// - status clears on functional read only
`timescale 1ns/1ps
`default_nettype none
module dcc_channel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:1] dma_req,
  input wire logic elem_done,
  input wire logic src_timeout,
  input wire logic dst_timeout,
  output logic move_req,
  output logic prio_high,
  output logic legacy_model_off,
  output logic [1:0] src_amode,
  output logic [1:0] dst_amode,
  output logic channel_irq
);
  // Software visible registers.
  logic [15:0] channel_control;
  logic [5:0] channel_interrupt_enables;
  logic block_per_request;
  logic [6:0] channel_status;
  logic [15:0] elems_per_frame;
  logic [15:0] frames_per_block;
  // Channel progress.
  dcc_pkg::dcc_state_t state;
  logic [15:0] elem_cnt;
  logic [15:0] frame_cnt;
  logic req_prev;
  // Write channel holding registers; address and data arrive in any order.
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Named views of the control fields.
  logic [4:0] req_sel;
  logic frame_per_request;
  logic enable;
  logic auto_init;
  logic repeat_on;
  logic end_prog;
  assign req_sel = channel_control[dcc_pkg::REQ_SEL_LSB +: dcc_pkg::REQ_SEL_W];
  assign frame_per_request = channel_control[dcc_pkg::FRAME_PER_REQ];
  assign enable = channel_control[dcc_pkg::ENABLE_BIT];
  assign auto_init = channel_control[dcc_pkg::AUTO_INIT_BIT];
  assign repeat_on = channel_control[dcc_pkg::REPEAT_BIT];
  assign end_prog = channel_control[dcc_pkg::END_PROG_BIT];

  // Static outputs straight from the control register flops, and the move grant from the state and enable.
  assign prio_high = channel_control[dcc_pkg::PRIO_BIT];
  assign legacy_model_off = channel_control[dcc_pkg::LEGACY_OFF_BIT];
  assign src_amode = channel_control[dcc_pkg::SRC_AMODE_LSB +: 2];
  assign dst_amode = channel_control[dcc_pkg::DST_AMODE_LSB +: 2];
  assign move_req = (state == dcc_pkg::ST_MOVE) && enable;

  // Selected request line; selector zero means no hardware request.
  logic synced;
  logic req_level;
  logic req_rise;
  assign synced = (req_sel != dcc_pkg::REQ_NONE);
  assign req_level = synced ? dma_req[req_sel] : 1'b0;
  assign req_rise = req_level && !req_prev;

  // Position within the block when an element completes.
  logic elem_step;
  logic frame_end;
  logic block_end;
  logic quantum_end;
  assign elem_step = move_req && elem_done;
  assign frame_end = elem_step && (elem_cnt == elems_per_frame - 16'h0001);
  assign block_end = frame_end && (frame_cnt == frames_per_block - 16'h0001);
  // The service quantum per request decides when to wait again.
  always_comb begin
    if (block_per_request) begin
      quantum_end = block_end;
    end else if (frame_per_request) begin
      quantum_end = frame_end;
    end else begin
      quantum_end = elem_step;
    end
  end

  // Completion decisions; autoinit reloads when repeat or end_prog allows.
  logic reload_ok;
  logic hw_clr_en;
  assign reload_ok = auto_init && (repeat_on || end_prog);
  // Without autoinit the channel stops and hardware drops enable.
  assign hw_clr_en = (block_end && !auto_init)
    || ((state == dcc_pkg::ST_HOLD) && enable && !auto_init);

  // Raw channel events before the enables are applied.
  logic [dcc_pkg::EV_W-1:0] events;
  logic [dcc_pkg::EV_W-1:0] fired;
  always_comb begin
    events = '0;
    events[dcc_pkg::EV_TIMEOUT] = enable && (src_timeout || dst_timeout);
    // A new request while the previous one is still served is dropped.
    events[dcc_pkg::EV_DROP] = synced && req_rise && move_req && !quantum_end;
    events[dcc_pkg::EV_HALF] = elem_step
      && (elem_cnt == (elems_per_frame >> 1) - 16'h0001) && (elems_per_frame > 16'h0001);
    events[dcc_pkg::EV_FRAME] = frame_end;
    // The last frame counts as started once its first element is moved.
    events[dcc_pkg::EV_LAST] = elem_step && (elem_cnt == 16'h0000)
      && (frame_cnt == frames_per_block - 16'h0001);
    events[dcc_pkg::EV_BLOCK] = block_end;
  end
  // Only enabled events reach the processor; the status register also takes the sync bit unmasked.
  assign fired = events & channel_interrupt_enables;

  // The interrupt is a one-cycle pulse per cycle with an enabled event.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_irq <= 1'b0;
    end else begin
      channel_irq <= |fired;
    end
  end

  // Request line history for the edge detector.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_prev <= 1'b0;
    end else begin
      req_prev <= req_level;
    end
  end

  // Channel state machine.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= dcc_pkg::ST_IDLE;
    end else if (!enable) begin
      // Dropping enable stops at once, even mid block.
      state <= dcc_pkg::ST_IDLE;
    end else begin
      case (state)
        dcc_pkg::ST_IDLE: begin
          state <= dcc_pkg::ST_ARMED;
        end
        dcc_pkg::ST_ARMED: begin
          // Unsynchronised channels start without waiting.
          if (!synced || req_rise) begin
            state <= dcc_pkg::ST_MOVE;
          end
        end
        dcc_pkg::ST_MOVE: begin
          if (block_end) begin
            if (!auto_init) begin
              state <= dcc_pkg::ST_IDLE;
            end else if (reload_ok) begin
              state <= dcc_pkg::ST_ARMED;
            end else begin
              state <= dcc_pkg::ST_HOLD;
            end
          end else if (quantum_end && synced) begin
            state <= dcc_pkg::ST_ARMED;
          end
        end
        dcc_pkg::ST_HOLD: begin
          // Waiting for software to set end_prog or to drop autoinit.
          if (!auto_init) begin
            state <= dcc_pkg::ST_IDLE;
          end else if (reload_ok) begin
            state <= dcc_pkg::ST_ARMED;
          end
        end
        default: begin
          state <= dcc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Element and frame counters; they restart on every new block.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      elem_cnt <= 16'h0000;
      frame_cnt <= 16'h0000;
    end else if (!enable || block_end) begin
      elem_cnt <= 16'h0000;
      frame_cnt <= 16'h0000;
    end else if (frame_end) begin
      elem_cnt <= 16'h0000;
      frame_cnt <= frame_cnt + 16'h0001;
    end else if (elem_step) begin
      elem_cnt <= elem_cnt + 16'h0001;
    end
  end

  // AXI handshakes; one write and one read are handled at a time.
  logic do_write;
  logic rd_take;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;

  // Capture address and data separately so either may come first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Address decode for the write response code.
  logic wr_mapped;
  always_comb begin
    case (aw_addr)
      dcc_pkg::OFS_CTRL, dcc_pkg::OFS_IEN, dcc_pkg::OFS_CTRL2, dcc_pkg::OFS_SHAPE: begin
        wr_mapped = 1'b1;
      end
      default: begin
        wr_mapped = 1'b0;
      end
    endcase
  end

  // Write response; status registers and unknown offsets give an error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dcc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Byte-lane merge of the incoming word with the old value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Control register; a hardware enable clear discards the same-cycle write.
  logic wr_ctrl;
  logic [31:0] ctrl_new;
  assign wr_ctrl = do_write && (aw_addr == dcc_pkg::OFS_CTRL);
  assign ctrl_new = merge({16'h0000, channel_control}, w_data, w_strb);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_control <= dcc_pkg::CTRL_RST;
    end else if (hw_clr_en) begin
      channel_control[dcc_pkg::ENABLE_BIT] <= 1'b0;
    end else if (wr_ctrl) begin
      channel_control <= ctrl_new[15:0];
    end
  end

  // Remaining writable registers.
  logic [31:0] ien_new;
  logic [31:0] ctrl2_new;
  assign ien_new = merge({26'h0, channel_interrupt_enables}, w_data, w_strb);
  assign ctrl2_new = merge({31'h0, block_per_request}, w_data, w_strb);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_interrupt_enables <= dcc_pkg::IEN_RST;
      block_per_request <= 1'b0;
      elems_per_frame <= dcc_pkg::SHAPE_RST[15:0];
      frames_per_block <= dcc_pkg::SHAPE_RST[31:16];
    end else if (do_write) begin
      case (aw_addr)
        dcc_pkg::OFS_IEN: begin
          channel_interrupt_enables <= ien_new[dcc_pkg::EV_W-1:0];
        end
        dcc_pkg::OFS_CTRL2: begin
          block_per_request <= ctrl2_new[dcc_pkg::BLOCK_PER_REQ];
        end
        dcc_pkg::OFS_SHAPE: begin
          {frames_per_block, elems_per_frame} <=
            merge({frames_per_block, elems_per_frame}, w_data, w_strb);
        end
        default: begin
          block_per_request <= block_per_request;
        end
      endcase
    end
  end

  // Status bits: set beats the read clear; the peek address never clears.
  logic stat_clr;
  logic [6:0] stat_set;
  assign stat_clr = rd_take && (s_axi_araddr[7:0] == dcc_pkg::OFS_STAT);
  assign stat_set = {(state == dcc_pkg::ST_ARMED) && synced && req_rise && enable, fired};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_status <= dcc_pkg::STAT_RST;
    end else if (stat_clr) begin
      channel_status <= stat_set;
    end else begin
      channel_status <= channel_status | stat_set;
    end
  end

  // Read data mux; the old status is returned before the clear lands.
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr[7:0])
      dcc_pkg::OFS_CTRL: rd_word = {16'h0000, channel_control};
      dcc_pkg::OFS_IEN: rd_word = {26'h0, channel_interrupt_enables};
      dcc_pkg::OFS_CTRL2: rd_word = {31'h0, block_per_request};
      dcc_pkg::OFS_STAT, dcc_pkg::OFS_PEEK: rd_word = {25'h0, channel_status};
      dcc_pkg::OFS_SHAPE: rd_word = {frames_per_block, elems_per_frame};
      default: rd_ok = 1'b0;
    endcase
  end

  // Read response registered one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= dcc_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : dcc_channel
`default_nettype wire

// ==== rtl/dcc_pkg.sv ====
package dcc_pkg;
  // Byte offsets of the registers on the AXI4-Lite slave.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IEN = 8'h04;
  localparam logic [7:0] OFS_CTRL2 = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_PEEK = 8'h10;
  localparam logic [7:0] OFS_SHAPE = 8'h14;
  // Field positions of channel_control.
  localparam int REQ_SEL_LSB = 0;
  localparam int REQ_SEL_W = 5;
  localparam int FRAME_PER_REQ = 5;
  localparam int PRIO_BIT = 6;
  localparam int ENABLE_BIT = 7;
  localparam int AUTO_INIT_BIT = 8;
  localparam int REPEAT_BIT = 9;
  localparam int LEGACY_OFF_BIT = 10;
  localparam int END_PROG_BIT = 11;
  localparam int SRC_AMODE_LSB = 12;
  localparam int DST_AMODE_LSB = 14;
  // Bit of channel_control_second.
  localparam int BLOCK_PER_REQ = 0;
  // Event bits of the status register; the enables take those below EV_W.
  localparam int EV_TIMEOUT = 0;
  localparam int EV_DROP = 1;
  localparam int EV_HALF = 2;
  localparam int EV_FRAME = 3;
  localparam int EV_LAST = 4;
  localparam int EV_BLOCK = 5;
  localparam int EV_SYNC = 6;
  localparam int EV_W = 6;
  // Values after reset.
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [5:0] IEN_RST = 6'h03;
  localparam logic [6:0] STAT_RST = 7'h00;
  localparam logic [31:0] SHAPE_RST = 32'h0001_0001;
  // Selector value of an unsynchronised channel.
  localparam logic [4:0] REQ_NONE = 5'h00;
  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Channel states, Gray coded along idle, armed, move, hold.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARMED = 2'h1,
    ST_MOVE = 2'h3,
    ST_HOLD = 2'h2
  } dcc_state_t;
endpackage : dcc_pkg

// ==== tb/dcc_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Datapath stand-in on the far side of the channel: it answers each element
// grant with a one-cycle completion, at once or, while slow is high, after a
// stall, so that a second request can land while an element is in flight.
module dcc_far_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic move_req,
  input wire logic slow,
  output logic elem_done
);
  // Stall counter; a real port may need several cycles per element.
  logic [1:0] wait_cnt;

  // A completion is only offered while the grant stands, and never twice in a row.
  always_ff @(posedge aclk) begin
    if (!aresetn || !move_req || elem_done) begin
      wait_cnt <= 2'h0;
      elem_done <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
      elem_done <= slow ? (wait_cnt == 2'h3) : 1'b1;
    end
  end
endmodule : dcc_far_model
`default_nettype wire

// ==== tb/dcc_channel_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the channel's ports; all checks run on one clock.
module dcc_channel_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:1] dma_req,
  input wire logic elem_done,
  input wire logic src_timeout,
  input wire logic dst_timeout,
  input wire logic move_req,
  input wire logic prio_high,
  input wire logic legacy_model_off,
  input wire logic [1:0] src_amode,
  input wire logic [1:0] dst_amode,
  input wire logic channel_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A write taken whole is answered together with the register update.
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[2:3] s_axi_bvalid) else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  // A pending response blocks new requests.
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  // Configuration outputs move only with a completed register write.
  a_cfg_by_write: assert property ($changed({prio_high, legacy_model_off, src_amode,
    dst_amode}) |-> $rose(s_axi_bvalid)) else $error("config changed alone");
  // Every interrupt pulse follows an element, a timeout or a request.
  a_irq_cause: assert property (channel_irq |-> $past(elem_done || src_timeout
    || dst_timeout || (|dma_req))) else $error("interrupt without cause");

  cover property ($rose(move_req));
  cover property (channel_irq);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule : dcc_channel_monitor

bind dcc_channel dcc_channel_monitor u_mon (.*);
`default_nettype wire

// ==== tb/dma_channel_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control_bench;
  // Bench-driven inputs, named as the ports so instances connect by name.
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slow = 1'b0;
  logic [31:1] dma_req = 31'h0;
  logic src_timeout = 1'b0, dst_timeout = 1'b0;
  // Outputs of the channel and of the far-side model.
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, src_amode, dst_amode;
  logic [31:0] s_axi_rdata;
  logic elem_done, move_req, prio_high, legacy_model_off, channel_irq, mv_q;
  int err_total = 0, n_compared = 0, n_rise = 0, n_elem = 0, n_irq = 0;

  dcc_channel dut (.*);
  dcc_far_model far (.*);

  always #5 aclk = ~aclk;

  // Event counters; tasks compare differences, never reset them.
  always @(posedge aclk) begin
    mv_q <= move_req;
    if (move_req && !mv_q) n_rise <= n_rise + 1;
    if (move_req && elem_done) n_elem <= n_elem + 1;
    if (channel_irq) n_irq <= n_irq + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  // Write; handshakes are judged at the falling edge so no race is possible.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (50) if (!done) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      if (done) check(s_axi_bresp, er);
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (done) s_axi_bready <= 1'b0;
    end
    check(done, 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_t, done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (50) if (!done) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      if (done) check(s_axi_rdata, ed);
      if (done) check(s_axi_rresp, er);
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
    end
    check(done, 1'b1);
  endtask : rd

  task automatic cfg(input logic [31:0] ien, shp, c2, c);
    wr(dcc_pkg::OFS_IEN, ien, dcc_pkg::RESP_OKAY);
    wr(dcc_pkg::OFS_SHAPE, shp, dcc_pkg::RESP_OKAY);
    wr(dcc_pkg::OFS_CTRL2, c2, dcc_pkg::RESP_OKAY);
    wr(dcc_pkg::OFS_CTRL, c, dcc_pkg::RESP_OKAY);
  endtask : cfg

  // Waits, bounded, for a count of grants and optionally for the grant to drop.
  task automatic wait_for(input int tgt, input logic idle);
    int k;
    k = 0;
    while ((n_rise < tgt || (idle && move_req)) && k < 300) begin
      @(negedge aclk);
      k++;
    end
    check(k < 300, 1'b1);
  endtask : wait_for

  // A request is a level held two cycles; its rising edge is what counts.
  task automatic pulse(input int ln);
    @(posedge aclk);
    dma_req[ln] <= 1'b1;
    repeat (2) @(posedge aclk);
    dma_req[ln] <= 1'b0;
  endtask : pulse

  task automatic tpulse(input logic s, input logic d);
    @(posedge aclk);
    src_timeout <= s;
    dst_timeout <= d;
    @(posedge aclk);
    src_timeout <= 1'b0;
    dst_timeout <= 1'b0;
  endtask : tpulse

  task automatic t_reset;
    rd(dcc_pkg::OFS_CTRL, 32'h0, dcc_pkg::RESP_OKAY);
    rd(dcc_pkg::OFS_IEN, 32'h3, dcc_pkg::RESP_OKAY);
    rd(dcc_pkg::OFS_SHAPE, 32'h0001_0001, dcc_pkg::RESP_OKAY);
    rd(8'h20, 32'h0, dcc_pkg::RESP_SLVERR);
    wr(dcc_pkg::OFS_STAT, 32'h7f, dcc_pkg::RESP_SLVERR);
    // Only the low byte lane is written; the other lanes keep their value.
    s_axi_wstrb <= 4'h1;
    wr(dcc_pkg::OFS_SHAPE, 32'h0005_0007, dcc_pkg::RESP_OKAY);
    rd(dcc_pkg::OFS_SHAPE, 32'h0001_0007, dcc_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    check(legacy_model_off, 1'b0);
    $display("t_reset done");
  endtask : t_reset

  // Every addressing mode on both ports, with priority and model bits.
  task automatic t_cfg;
    logic [1:0] m;
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      // Autoinit bits stay zero whenever the newer model is chosen.
      d = {16'h0, m, ~m, 1'b0, m[0], 3'h0, m[1], 6'h0};
      wr(dcc_pkg::OFS_CTRL, d, dcc_pkg::RESP_OKAY);
      check(dst_amode, d[15:14]);
      check(src_amode, d[13:12]);
      check(prio_high, d[6]);
      check(legacy_model_off, d[10]);
      rd(dcc_pkg::OFS_CTRL, d, dcc_pkg::RESP_OKAY);
    end
    wr(dcc_pkg::OFS_CTRL, 32'h0, dcc_pkg::RESP_OKAY);
    $display("t_cfg done");
  endtask : t_cfg

  // Unsynchronised block with every event masked: no status, no interrupt.
  task automatic t_mask;
    int r0, i0;
    r0 = n_rise;
    i0 = n_irq;
    cfg(32'h0, 32'h0001_0002, 32'h0, 32'h80);
    wait_for(r0 + 1, 1'b1);
    rd(dcc_pkg::OFS_CTRL, 32'h0, dcc_pkg::RESP_OKAY);
    rd(dcc_pkg::OFS_STAT, 32'h0, dcc_pkg::RESP_OKAY);
    check(n_irq - i0, 0);
    $display("t_mask done");
  endtask : t_mask

  task automatic t_block;
    int r0, i0;
    r0 = n_rise;
    i0 = n_irq;
    cfg(32'h3f, 32'h0001_0002, 32'h0, 32'h80);
    wait_for(r0 + 1, 1'b1);
    rd(dcc_pkg::OFS_CTRL, 32'h0, dcc_pkg::RESP_OKAY);
    rd(dcc_pkg::OFS_PEEK, 32'h3c, dcc_pkg::RESP_OKAY);
    rd(dcc_pkg::OFS_STAT, 32'h3c, dcc_pkg::RESP_OKAY);
    rd(dcc_pkg::OFS_STAT, 32'h0, dcc_pkg::RESP_OKAY);
    check(n_irq > i0, 1'b1);
    $display("t_block done");
  endtask : t_block

  // Element per request, foreign line ignored, collision while stalled.
  task automatic t_sync;
    int r0, e0;
    r0 = n_rise;
    e0 = n_elem;
    cfg(32'h3f, 32'h0001_0002, 32'h0, 32'h85);
    pulse(6);
    repeat (4) @(posedge aclk);
    check(n_rise - r0, 0);
    slow <= 1'b1;
    dma_req[5] <= 1'b1;
    wait_for(r0 + 1, 1'b0);
    @(posedge aclk);
    dma_req[5] <= 1'b0;
    @(posedge aclk);
    dma_req[5] <= 1'b1;
    wait_for(r0 + 1, 1'b1);
    check(n_elem - e0, 1);
    tpulse(1'b1, 1'b0);
    dma_req[5] <= 1'b0;
    @(posedge aclk);
    dma_req[5] <= 1'b1;
    wait_for(r0 + 2, 1'b1);
    dma_req[5] <= 1'b0;
    slow <= 1'b0;
    rd(dcc_pkg::OFS_CTRL, 32'h05, dcc_pkg::RESP_OKAY);
    rd(dcc_pkg::OFS_STAT, 32'h7f, dcc_pkg::RESP_OKAY);
    $display("t_sync done");
  endtask : t_sync

  // Frame per request, then a cleared enable ignores further requests.
  task automatic t_frame;
    int r0, e0;
    r0 = n_rise;
    e0 = n_elem;
    cfg(32'h0, 32'h0002_0002, 32'h0, 32'ha5);
    pulse(5);
    wait_for(r0 + 1, 1'b1);
    check(n_elem - e0, 2);
    wr(dcc_pkg::OFS_CTRL, 32'h25, dcc_pkg::RESP_OKAY);
    pulse(5);
    repeat (6) @(posedge aclk);
    check(n_rise - r0, 1);
    rd(dcc_pkg::OFS_STAT, 32'h40, dcc_pkg::RESP_OKAY);
    $display("t_frame done");
  endtask : t_frame

  // Block per request; frame mode stays clear while block mode is set.
  task automatic t_bmode;
    int r0, e0;
    r0 = n_rise;
    e0 = n_elem;
    cfg(32'h3f, 32'h0002_0002, 32'h1, 32'h85);
    tpulse(1'b0, 1'b1);
    pulse(5);
    wait_for(r0 + 1, 1'b1);
    check(n_elem - e0, 4);
    rd(dcc_pkg::OFS_CTRL, 32'h05, dcc_pkg::RESP_OKAY);
    rd(dcc_pkg::OFS_STAT, 32'h7d, dcc_pkg::RESP_OKAY);
    wr(dcc_pkg::OFS_CTRL2, 32'h0, dcc_pkg::RESP_OKAY);
    $display("t_bmode done");
  endtask : t_bmode

  // Autoinit with repeat, stop by enable, hold without end_prog, stop by autoinit.
  task automatic t_auto;
    int r0, r1;
    r0 = n_rise;
    cfg(32'h0, 32'h0001_0001, 32'h0, 32'h380);
    wait_for(r0 + 3, 1'b0);
    rd(dcc_pkg::OFS_CTRL, 32'h380, dcc_pkg::RESP_OKAY);
    wr(dcc_pkg::OFS_CTRL, 32'h300, dcc_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    r1 = n_rise;
    repeat (8) @(posedge aclk);
    check(n_rise - r1, 0);
    wr(dcc_pkg::OFS_CTRL, 32'h180, dcc_pkg::RESP_OKAY);
    wait_for(r1 + 1, 1'b1);
    repeat (8) @(posedge aclk);
    check(n_rise - r1, 1);
    wr(dcc_pkg::OFS_CTRL, 32'h980, dcc_pkg::RESP_OKAY);
    wait_for(r1 + 3, 1'b0);
    wr(dcc_pkg::OFS_CTRL, 32'h880, dcc_pkg::RESP_OKAY);
    repeat (10) @(posedge aclk);
    rd(dcc_pkg::OFS_CTRL, 32'h800, dcc_pkg::RESP_OKAY);
    $display("t_auto done");
  endtask : t_auto

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // The whole run needs a few hundred cycles; this limit is far above it.
  initial begin
    #300000;
    err_total++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_cfg();
    t_mask();
    t_block();
    t_sync();
    t_frame();
    t_bmode();
    t_auto();
    test_done();
  end
endmodule : dma_channel_control_bench
`default_nettype wire
